// file: shared/hub_cfg_regs.svh
`ifndef HUB_CFG_REGS_SVH
`define HUB_CFG_REGS_SVH
// Summary of operation
// - Power-source strap low means bus-powered, high means self-powered.
// - Reset or power strap change drops pullup enable and restarts 3 ms.
// - After 3 ms the pullup enable goes high until the next restart.
// - Prom select high disables the prom port and its clock output.
// - Prom select low: clock pin is driven, data pin is two-way.
// - Prom select high: data pin is read as the ganged-mode strap.
// - Bus-powered hub always reports its ports as power-switched.
// - Bus-powered: descriptor bit D4 follows the protect/switch strap.
// - Self-powered hub always reports overcurrent protection provided.
// - Self-powered: power-good time 50 units if strap low, else 0.
// - Pulldown on the protect/switch strap is off while it reads high.
// - Prom used: identifiers and gang mode from prom, else default identifiers and strap gang mode.
// - Ganged: all power enables together; per-port: each its own.

// Register byte offsets
`define STATUS_OFS      12'h000
`define PORT_CTRL_OFS   12'h004
`define PROM_IDS_OFS    12'h008
`define PROM_CTRL_OFS   12'h00C
`define DESC_OFS        12'h010
`define IDS_OFS         12'h014

// Reset values
`define PORT_CTRL_RST   32'h0000_0000
`define PROM_IDS_RST    32'h0000_0000
`define PROM_CTRL_RST   32'h0000_0000

// Prom control field positions
`define PC_GANG         0
`define PC_CLK          1
`define PC_DOUT         2
`define PC_DRIVE        3

// Status field positions
`define ST_BUS_POWERED  0
`define ST_PROM_OFF     1
`define ST_GANGED       2
`define ST_PROT_STRAP   3
`define ST_PULLUP_ON    4
`define ST_OVERCURRENT  5
`define ST_PWR_LSB      8

// Hub characteristics field positions
`define HC_PSW_LSB      0
`define HC_OCP_PORT     3
`define HC_OCP_NONE     4

// Power-on to power-good values, in 2 ms units
`define PWRGOOD_SWITCHED 8'h32
`define PWRGOOD_NONE     8'h00

// Timing
`define CLK_PERIOD_NS   10
`define PULLUP_DELAY_NS 3000000
`endif

// file: shared/hub_cfg_pkg.sv
package hub_cfg_pkg;
  // Pullup delay sequencer
  typedef enum logic {PU_HOLD, PU_DRIVE} pullup_state_t;

  // Hub descriptor fields reported upstream
  typedef struct packed {
    logic [7:0] pwr_good;
    logic [7:0] hub_char;
  } hub_desc_t;
endpackage

// file: shared/hub_cfg_if.sv
`timescale 1ns/1ns
interface hub_cfg_if;
  logic restart;
  logic expired;
  logic ganged;

  modport ctrl  (output restart, output ganged, input expired);
  modport timer (input restart, output expired);
  modport power (input ganged);
endinterface

// file: hw/pullup_delay.sv
`timescale 1ns/1ns
module pullup_delay #(
  parameter int unsigned CYCLES = 300000,
  parameter int unsigned CW     = 19
) (
  input  wire logic      hclk,
  input  wire logic      hresetn,
  input  wire logic      ce,
  hub_cfg_if.timer       cfg
);
  import hub_cfg_pkg::*;

  pullup_state_t   state_q, state_d;
  logic [CW-1:0]   cnt_q, cnt_d;
  logic            expired_q, expired_d;

  // Next state: restart always wins over counting
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    if (cfg.restart) begin
      state_d = PU_HOLD;
      cnt_d   = '0;
    end else begin
      case (state_q)
        PU_HOLD: begin
          if (cnt_q == CW'(CYCLES - 1)) begin
            state_d = PU_DRIVE;
          end else begin
            cnt_d = cnt_q + CW'(1);
          end
        end
        PU_DRIVE: state_d = PU_DRIVE;
        default:  state_d = PU_HOLD;
      endcase
    end
    expired_d = (state_d == PU_DRIVE);
  end

  // Reset lands in hold, so reset also starts the delay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q   <= PU_HOLD;
      cnt_q     <= '0;
      expired_q <= 1'b0;
    end else if (ce) begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      expired_q <= expired_d;
    end
  end

  assign cfg.expired = expired_q;
endmodule

// file: hw/port_power.sv
`timescale 1ns/1ns
module port_power #(
  parameter int unsigned PORTS = 3
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             ce,
  hub_cfg_if.power              cfg,
  input  wire logic [PORTS-1:0] port_req,
  input  wire logic [PORTS-1:0] port_overcurrent_in_n,
  output logic      [PORTS-1:0] port_power_enable_n,
  output logic                  overcurrent
);
  logic [PORTS-1:0] en_n_q, en_n_d;
  logic             oc_q, oc_d;

  // Ganged ports follow port 0 and any overcurrent drops all of them
  always_comb begin
    oc_d = ~&port_overcurrent_in_n;
    if (cfg.ganged) begin
      en_n_d = {PORTS{~(port_req[0] & ~oc_d)}};
    end else begin
      en_n_d = ~(port_req & port_overcurrent_in_n);
    end
  end

  // Outputs are active low, so reset keeps every port unpowered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_n_q <= {PORTS{1'b1}};
      oc_q   <= 1'b0;
    end else if (ce) begin
      en_n_q <= en_n_d;
      oc_q   <= oc_d;
    end
  end

  assign port_power_enable_n = en_n_q;
  assign overcurrent         = oc_q;
endmodule

// file: hw/hub_power_config_straps.sv
`timescale 1ns/1ns
`include "hub_cfg_regs.svh"
module hub_power_config_straps #(
  parameter int unsigned PORTS         = 3,
  parameter int unsigned PULLUP_CYCLES =
    (`PULLUP_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter logic [15:0] DEFAULT_VID   = 16'h1234, // Arbitrary value
  parameter logic [15:0] DEFAULT_PID   = 16'h5678  // Arbitrary value
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             ce,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  // Straps
  input  wire logic             power_source_strap,
  input  wire logic             external_prom_select,
  input  wire logic             protect_or_switch_strap,
  output logic                  strap_pulldown_enable,
  // Shared prom pins
  output logic                  prom_serial_clock_out,
  output logic                  prom_serial_clock_oe_n,
  input  wire logic             prom_data_or_gang_strap_in,
  output logic                  prom_data_or_gang_strap_out,
  output logic                  prom_data_or_gang_strap_oe_n,
  // Upstream and downstream power
  output logic                  upstream_pullup_enable,
  input  wire logic [PORTS-1:0] port_overcurrent_in_n,
  output logic      [PORTS-1:0] port_power_enable_n
);
  import hub_cfg_pkg::*;

  // --------------------------------------------------------------
  // Strap sampling
  // --------------------------------------------------------------
  logic pwr_s1_q, pwr_s2_q, pwr_s3_q;
  logic [2:0] arm_q, arm_d;
  logic prom_off_q, prot_q, gang_pin_q, pd_en_q;
  logic prom_off_d, prot_d, gang_pin_d, pd_en_d;

  // Next values of the sampled straps
  always_comb begin
    prom_off_d = external_prom_select;
    prot_d     = protect_or_switch_strap;
    pd_en_d    = ~protect_or_switch_strap;
    arm_d      = {arm_q[1:0], 1'b1};                     // Fills in 3 edges
    // Pin only means a strap while the prom port is off
    gang_pin_d = external_prom_select ?
                 prom_data_or_gang_strap_in : gang_pin_q;
  end

  // The power strap may move at any time, so it gets two stages
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_s1_q   <= 1'b0;
      pwr_s2_q   <= 1'b0;
      pwr_s3_q   <= 1'b0;
      arm_q      <= 3'h0;
      prom_off_q <= 1'b0;
      prot_q     <= 1'b0;
      gang_pin_q <= 1'b0;
      pd_en_q    <= 1'b1;
    end else if (ce) begin
      pwr_s1_q   <= power_source_strap;
      pwr_s2_q   <= pwr_s1_q;
      pwr_s3_q   <= pwr_s2_q;
      arm_q      <= arm_d;
      prom_off_q <= prom_off_d;
      prot_q     <= prot_d;
      gang_pin_q <= gang_pin_d;
      pd_en_q    <= pd_en_d;
    end
  end

  // --------------------------------------------------------------
  // Shared configuration to the leaf modules
  // --------------------------------------------------------------
  hub_cfg_if cfg ();

  logic [31:0] port_ctrl_q, prom_ids_q, prom_ctrl_q;
  logic        bus_powered;
  logic        overcurrent;

  // Either edge of the synchronised strap restarts the delay
  // Until the stages hold real samples a high strap would look like an edge
  assign cfg.restart = (pwr_s2_q ^ pwr_s3_q) & arm_q[2];
  assign bus_powered = ~pwr_s2_q;
  // Gang mode comes from the strap pin or from the prom contents
  assign cfg.ganged  = prom_off_q ? gang_pin_q
                     : prom_ctrl_q[`PC_GANG];

  pullup_delay #(
    .CYCLES (PULLUP_CYCLES),
    .CW     ($clog2(PULLUP_CYCLES + 1))
  ) u_delay (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .cfg     (cfg.timer)
  );

  port_power #(
    .PORTS (PORTS)
  ) u_power (
    .hclk                  (hclk),
    .hresetn               (hresetn),
    .ce                    (ce),
    .cfg                   (cfg.power),
    .port_req              (port_ctrl_q[PORTS-1:0]),
    .port_overcurrent_in_n (port_overcurrent_in_n),
    .port_power_enable_n   (port_power_enable_n),
    .overcurrent           (overcurrent)
  );

  assign upstream_pullup_enable = cfg.expired;

  // --------------------------------------------------------------
  // Hub descriptor and identifiers
  // --------------------------------------------------------------
  hub_desc_t   desc_q, desc_d;
  logic [31:0] ids_q, ids_d;

  // Field values reported to the host, rebuilt every cycle
  always_comb begin
    desc_d = '0;
    if (bus_powered) begin
      // Bus-powered ports are always reported switched
      desc_d.hub_char[`HC_PSW_LSB +: 2] =
        cfg.ganged ? 2'b00 : 2'b01;
      desc_d.hub_char[`HC_OCP_NONE] = prot_q;
      desc_d.hub_char[`HC_OCP_PORT] = ~prot_q & ~cfg.ganged;
      desc_d.pwr_good = `PWRGOOD_SWITCHED;
    end else begin
      desc_d.hub_char[`HC_OCP_NONE] = 1'b0;
      desc_d.hub_char[`HC_OCP_PORT] = ~cfg.ganged;
      if (prot_q) begin
        desc_d.hub_char[`HC_PSW_LSB +: 2] = 2'b10;
        desc_d.pwr_good = `PWRGOOD_NONE;
      end else begin
        desc_d.hub_char[`HC_PSW_LSB +: 2] =
          cfg.ganged ? 2'b00 : 2'b01;
        desc_d.pwr_good = `PWRGOOD_SWITCHED;
      end
    end
    ids_d = prom_off_q ? {DEFAULT_PID, DEFAULT_VID}
                       : prom_ids_q;
  end

  // Registered so a read never sees a half-updated field
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      desc_q <= '0;
      ids_q  <= 32'h0000_0000;
    end else if (ce) begin
      desc_q <= desc_d;
      ids_q  <= ids_d;
    end
  end

  // --------------------------------------------------------------
  // Prom pins
  // --------------------------------------------------------------
  logic sck_q, sck_oe_n_q, sda_q, sda_oe_n_q;
  logic sck_d, sck_oe_n_d, sda_d, sda_oe_n_d;

  // With the prom off both pins float; the clock is held low inside
  always_comb begin
    sck_oe_n_d = prom_off_q;
    sck_d      = ~prom_off_q & prom_ctrl_q[`PC_CLK];
    sda_oe_n_d = prom_off_q | ~prom_ctrl_q[`PC_DRIVE];
    sda_d      = ~prom_off_q & prom_ctrl_q[`PC_DOUT];
  end

  // Pin drivers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck_q      <= 1'b0;
      sck_oe_n_q <= 1'b1;
      sda_q      <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end else if (ce) begin
      sck_q      <= sck_d;
      sck_oe_n_q <= sck_oe_n_d;
      sda_q      <= sda_d;
      sda_oe_n_q <= sda_oe_n_d;
    end
  end

  assign prom_serial_clock_out        = sck_q;
  assign prom_serial_clock_oe_n       = sck_oe_n_q;
  assign prom_data_or_gang_strap_out  = sda_q;
  assign prom_data_or_gang_strap_oe_n = sda_oe_n_q;
  assign strap_pulldown_enable        = pd_en_q;

  // --------------------------------------------------------------
  // AHB-Lite register slave
  // --------------------------------------------------------------
  logic        wr_pend_q, wr_pend_d;
  logic [11:0] wr_addr_q, wr_addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] port_ctrl_d, prom_ids_d, prom_ctrl_d;
  logic        take;
  logic [31:0] status;

  // Live state that software can read back
  always_comb begin
    status = '0;
    status[`ST_BUS_POWERED] = bus_powered;
    status[`ST_PROM_OFF]    = prom_off_q;
    status[`ST_GANGED]      = cfg.ganged;
    status[`ST_PROT_STRAP]  = prot_q;
    status[`ST_PULLUP_ON]   = cfg.expired;
    status[`ST_OVERCURRENT] = overcurrent;
    status[`ST_PWR_LSB +: PORTS] = ~port_power_enable_n;
  end

  // Read decode; unmapped words read as zero
  function automatic logic [31:0] reg_read(input logic [11:0] a);
    case (a)
      `STATUS_OFS:    reg_read = status;
      `PORT_CTRL_OFS: reg_read = port_ctrl_q;
      `PROM_IDS_OFS:  reg_read = prom_ids_q;
      `PROM_CTRL_OFS: reg_read = prom_ctrl_q;
      `DESC_OFS:      reg_read = {16'h0000, desc_q};
      `IDS_OFS:       reg_read = ids_q;
      default:        reg_read = 32'h0000_0000;
    endcase
  endfunction

  assign take = hsel & htrans[1] & hready;

  // Reads answer with no wait; writes land in the data phase
  always_comb begin
    wr_pend_d   = take & hwrite;
    wr_addr_d   = take ? {haddr[11:2], 2'b00} : wr_addr_q;
    rdata_d     = (take & ~hwrite) ? reg_read({haddr[11:2], 2'b00})
                                   : rdata_q;
    port_ctrl_d = port_ctrl_q;
    prom_ids_d  = prom_ids_q;
    prom_ctrl_d = prom_ctrl_q;
    if (wr_pend_q) begin
      case (wr_addr_q)
        `PORT_CTRL_OFS: port_ctrl_d = {{(32-PORTS){1'b0}},
                                       hwdata[PORTS-1:0]};
        `PROM_IDS_OFS:  prom_ids_d  = hwdata;
        `PROM_CTRL_OFS: prom_ctrl_d = {28'h0000000, hwdata[3:0]};
        default:        port_ctrl_d = port_ctrl_q;
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 12'h000;
      rdata_q     <= 32'h0000_0000;
      port_ctrl_q <= `PORT_CTRL_RST;
      prom_ids_q  <= `PROM_IDS_RST;
      prom_ctrl_q <= `PROM_CTRL_RST;
    end else if (ce) begin
      wr_pend_q   <= wr_pend_d;
      wr_addr_q   <= wr_addr_d;
      rdata_q     <= rdata_d;
      port_ctrl_q <= port_ctrl_d;
      prom_ids_q  <= prom_ids_d;
      prom_ctrl_q <= prom_ctrl_d;
    end
  end

  // Zero-wait slave; the response flops only hold constants
  logic ready_q, resp_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_q <= 1'b1;
      resp_q  <= 1'b0;
    end else if (ce) begin
      ready_q <= 1'b1;
      resp_q  <= 1'b0;
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = ready_q;
  assign hresp     = resp_q;
endmodule

// file: tb/hub_cfg_assertions.sv
`timescale 1ns/1ns
module hub_cfg_assertions #(
  parameter int unsigned PORTS         = 3,
  parameter int unsigned PULLUP_CYCLES = 20
) (
  input wire logic             hclk,
  input wire logic             hresetn,
  input wire logic             power_source_strap,
  input wire logic             external_prom_select,
  input wire logic             protect_or_switch_strap,
  input wire logic             strap_pulldown_enable,
  input wire logic             prom_serial_clock_oe_n,
  input wire logic             prom_data_or_gang_strap_in,
  input wire logic             prom_data_or_gang_strap_oe_n,
  input wire logic             upstream_pullup_enable,
  input wire logic [PORTS-1:0] port_overcurrent_in_n,
  input wire logic [PORTS-1:0] port_power_enable_n
);
  logic [31:0] low_q, low_d;
  logic [3:0]  since_q, since_d;
  logic        strap_q, strap_d;

  // Pullup low time, and a saturating age of the last strap edge
  always_comb begin
    low_d   = upstream_pullup_enable ? 32'h0000_0000
                                     : low_q + 32'h0000_0001;
    strap_d = power_source_strap;
    since_d = (power_source_strap != strap_q) ? 4'h0 :
              (since_q == 4'hF) ? since_q : since_q + 4'h1;
  end

  // Age starts at zero so the first edges after reset stay lenient
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_q   <= 32'h0000_0000;
      since_q <= 4'h0;
      strap_q <= 1'b0;
    end else begin
      low_q   <= low_d;
      since_q <= since_d;
      strap_q <= strap_d;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_pullup_restart: assert property (
    $changed(power_source_strap) |-> ##[1:5] !upstream_pullup_enable)
    else $error("pullup not dropped after strap edge");
  a_pullup_fall: assert property (
    $fell(upstream_pullup_enable) |-> since_q < 4'h8)
    else $error("pullup dropped without strap edge");
  a_pullup_rise: assert property (
    $rose(upstream_pullup_enable) |-> low_q >= PULLUP_CYCLES)
    else $error("pullup rose too early");
  a_pullup_bound: assert property (
    low_q <= PULLUP_CYCLES + 16)
    else $error("pullup held low too long");
  a_prom_off: assert property (
    external_prom_select [*4] |->
      prom_serial_clock_oe_n && prom_data_or_gang_strap_oe_n)
    else $error("prom pins driven while disabled");
  a_data_drive: assert property (
    !prom_data_or_gang_strap_oe_n |->
      !($past(external_prom_select) && $past(external_prom_select, 2)))
    else $error("data pin driven with prom off");
  a_pulldown_off: assert property (
    protect_or_switch_strap |=> !strap_pulldown_enable)
    else $error("pulldown on while strap high");
  a_gang_together: assert property (
    (external_prom_select && prom_data_or_gang_strap_in) [*4] |->
      port_power_enable_n == {PORTS{port_power_enable_n[0]}})
    else $error("ganged enables differ");
  a_ovr_cut: assert property (
    !(&port_overcurrent_in_n) |=>
      &(port_power_enable_n | $past(port_overcurrent_in_n)))
    else $error("port powered during overcurrent");
endmodule

bind hub_power_config_straps hub_cfg_assertions #(
  .PORTS(PORTS),
  .PULLUP_CYCLES(PULLUP_CYCLES)
) chk_u (.*);

// file: tb/prom_board_model.sv
`timescale 1ns/1ns
module prom_board_model (
  input  wire logic prom_sel,
  input  wire logic gang_lvl,
  input  wire logic d_out,
  input  wire logic d_oe_n,
  output logic      d_in
);
  // Hub drive wins; else the board strap, else the internal pulldown
  always_comb begin
    if (!d_oe_n)
      d_in = d_out;
    else if (prom_sel)
      d_in = gang_lvl; // Held fixed by the board
    else
      d_in = 1'b0; // Prom silent, pulldown wins
  end
endmodule

// file: tb/tb_hub_power_config_straps.sv
`timescale 1ns/1ns
`include "hub_cfg_regs.svh"
module tb_hub_power_config_straps;
  localparam int unsigned P   = 3;
  localparam int unsigned PU  = 20;
  localparam logic [15:0] VENDOR_IDENTIFIER = 16'h0A0B; // Arbitrary value
  localparam logic [15:0] PRODUCT_IDENTIFIER = 16'h0C0D; // Arbitrary value

  logic         hclk    = 1'b0;
  logic         hresetn = 1'b0;
  logic [31:0]  haddr   = 32'h0;
  logic [31:0]  hwdata  = 32'h0;
  logic [1:0]   htrans  = 2'h0;
  logic         hwrite  = 1'b0;
  logic         ps      = 1'b0;
  logic         sel     = 1'b1;
  logic         prot    = 1'b0;
  logic         gang    = 1'b0;
  logic [P-1:0] ovr_n   = 3'h7;
  logic [31:0]  hrdata;
  logic [P-1:0] pwr_n;
  logic         hready, pd, ck, ck_oe_n, d_in, d_out, d_oe_n, pu, hresp;
  int           n_mismatch = 0;
  int           checked    = 0;

  always #5 hclk = ~hclk;

  hub_power_config_straps #(.PORTS(P), .PULLUP_CYCLES(PU),
    .DEFAULT_VID(VENDOR_IDENTIFIER), .DEFAULT_PID(PRODUCT_IDENTIFIER)) dut (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .power_source_strap(ps),
    .external_prom_select(sel), .protect_or_switch_strap(prot),
    .strap_pulldown_enable(pd), .prom_serial_clock_out(ck),
    .prom_serial_clock_oe_n(ck_oe_n), .prom_data_or_gang_strap_in(d_in),
    .prom_data_or_gang_strap_out(d_out),
    .prom_data_or_gang_strap_oe_n(d_oe_n),
    .upstream_pullup_enable(pu), .port_overcurrent_in_n(ovr_n),
    .port_power_enable_n(pwr_n));

  prom_board_model pm (.prom_sel(sel), .gang_lvl(gang), .d_out(d_out),
    .d_oe_n(d_oe_n), .d_in(d_in));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_in(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("[ERR] %0t count %0d out of range", $time, got);
    end
  endtask

  task automatic fail_to();
    n_mismatch++;
    $display("[ERR] %0t wait ran out", $time);
    close_out();
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge hclk);
  endtask

  // Address phase held until hready, then data phase until hready
  task automatic xfer(input logic [31:0] a, input logic w,
                      input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 20);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 20);
    if (n >= 20) fail_to();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0); // Slave always answers OKAY
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(a, 1'b1, d, x);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    logic [31:0] x;
    xfer(a, 1'b0, 32'h0, x);
    chk(x & m, exp);
  endtask

  task automatic wait_pu(input logic lvl, input int lim, output int n);
    n = 0;
    do begin @(posedge hclk); n++; end while (pu !== lvl && n < lim);
    if (pu !== lvl) fail_to();
  endtask

  // Straps settle before reset lifts
  task automatic do_reset();
    int n;
    hresetn <= 1'b0;
    idle(20);
    chk(pu, 1'b0);
    hresetn <= 1'b1;
    wait_pu(1'b1, PU + 10, n);
    chk(n, PU + 1);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_power();
    logic [1:0] sq [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
    logic [7:0] pg;
    int         n;
    for (int i = 0; i < 4; i++) begin
      prot <= sq[i][0];
      if (ps !== sq[i][1]) begin
        ps <= sq[i][1];
        wait_pu(1'b0, 8, n);
        wait_pu(1'b1, PU + 10, n);
        chk_in(n, PU - 2, PU + 4);
      end else begin
        idle(4);
      end
      pg = (sq[i] == 2'h3) ? 8'h00 : 8'h32;
      rd_chk(32'(`DESC_OFS), 32'hFF13, {16'h0, pg, 3'h0,
        !sq[i][1] & sq[i][0], 2'h0,
        (sq[i] == 2'h3) ? 2'h2 : 2'h1});
      rd_chk(32'(`STATUS_OFS), 32'h1, {31'h0, !sq[i][1]});
      chk(pd, !sq[i][0]);
    end
    $display("t_power done");
  endtask

  task automatic t_gang();
    gang <= 1'b1;
    ps   <= 1'b1; // Self-powered across reset: no false strap edge
    do_reset();
    chk({ck_oe_n, d_oe_n}, 2'h3);
    rd_chk(32'(`STATUS_OFS), 32'h6, 32'h6);
    rd_chk(32'(`IDS_OFS), 32'hFFFF_FFFF, {PRODUCT_IDENTIFIER, VENDOR_IDENTIFIER});
    wr(32'(`PORT_CTRL_OFS), 32'h1);
    idle(2);
    chk(pwr_n, 3'h0);
    rd_chk(32'(`STATUS_OFS), 32'h730, 32'h710);
    ovr_n <= 3'h3;
    idle(3);
    chk(pwr_n, 3'h7);
    rd_chk(32'(`STATUS_OFS), 32'h730, 32'h30);
    ovr_n <= 3'h7;
    $display("t_gang done");
  endtask

  task automatic t_prom();
    sel  <= 1'b0;
    gang <= 1'b0;
    ps   <= 1'b0;
    do_reset();
    wr(32'(`PROM_IDS_OFS), 32'hA5A5_5A5A);
    idle(1); // Reported identifiers are copied one cycle later
    rd_chk(32'(`IDS_OFS), 32'hFFFF_FFFF, 32'hA5A5_5A5A);
    wr(32'(`PROM_CTRL_OFS), 32'hE);
    idle(2);
    chk({ck_oe_n, ck, d_oe_n, d_out, d_in}, 5'h0B);
    wr(32'(`PROM_CTRL_OFS), 32'h1);
    idle(2);
    chk({ck_oe_n, d_oe_n, d_in}, 3'h2);
    rd_chk(32'(`STATUS_OFS), 32'h6, 32'h4);
    wr(32'(`PROM_CTRL_OFS), 32'h0);
    wr(32'(`PORT_CTRL_OFS), 32'h5);
    ovr_n <= 3'h6;
    idle(3);
    chk(pwr_n, 3'h3);
    ovr_n <= 3'h7;
    rd_chk(32'h20, 32'hFFFF_FFFF, 32'h0);
    wr(32'(`DESC_OFS), 32'hFFFF_FFFF);
    rd_chk(32'(`DESC_OFS), 32'hFF13, 32'h3201);
    $display("t_prom done");
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    do_reset();
    t_power();
    t_gang();
    t_prom();
    close_out();
  end
endmodule
